//--- design/aex_map.vh
`ifndef AEX_MAP_VH
`define AEX_MAP_VH

// register byte offsets
`define AEX_OFF_CTRL 8'h00
`define AEX_OFF_OPER 8'h04
`define AEX_OFF_PC 8'h08
`define AEX_OFF_ZPTR 8'h0c
`define AEX_OFF_FLAGS 8'h10
`define AEX_OFF_RESULT 8'h14
`define AEX_OFF_STATUS 8'h18

// control register fields
`define AEX_CTRL_OP_LSB 0
`define AEX_CTRL_BIT_LSB 5
`define AEX_CTRL_TWO_WORD 8
`define AEX_CTRL_K_LSB 16
`define AEX_CTRL_START 31

// operand register byte lanes
`define AEX_OPER_RD_LSB 0
`define AEX_OPER_RR_LSB 8
`define AEX_OPER_K_LSB 16
`define AEX_OPER_IO_LSB 24

// status flag positions
`define AEX_FLAG_C 0
`define AEX_FLAG_Z 1
`define AEX_FLAG_N 2
`define AEX_FLAG_V 3
`define AEX_FLAG_S 4
`define AEX_FLAG_H 5

// reset values
`define AEX_RST_WORD 32'h0000_0000
`define AEX_RST_PC 16'h0000
`define AEX_RST_FLAGS 8'h00

// cycle counts
`define AEX_CYC_ONE 2'h1
`define AEX_CYC_TWO 2'h2
`define AEX_CYC_THREE 2'h3

// operation codes
`define AEX_OP_ADD 5'h00
`define AEX_OP_ADD_CARRY 5'h01
`define AEX_OP_WORD_ADD_IMMEDIATE 5'h02
`define AEX_OP_SUB 5'h03
`define AEX_OP_SUBTRACT_IMMEDIATE 5'h04
`define AEX_OP_SUBTRACT_WITH_CARRY 5'h05
`define AEX_OP_SUBTRACT_IMMEDIATE_WITH_CARRY 5'h06
`define AEX_OP_WORD_SUBTRACT_IMMEDIATE 5'h07
`define AEX_OP_AND 5'h08
`define AEX_OP_AND_WITH_CONSTANT 5'h09
`define AEX_OP_OR 5'h0a
`define AEX_OP_OR_WITH_CONSTANT 5'h0b
`define AEX_OP_SET_BITS_OP 5'h0c
`define AEX_OP_CLEAR_BITS_OP 5'h0d
`define AEX_OP_REGISTER_TEST_OP 5'h0e
`define AEX_OP_POINTER_JUMP 5'h0f
`define AEX_OP_POINTER_CALL 5'h10
`define AEX_OP_COMPARE_SKIP_EQUAL 5'h11
`define AEX_OP_COMPARE_WITH_CONSTANT 5'h12
`define AEX_OP_SKIP_REG_BIT_CLEAR 5'h13
`define AEX_OP_SKIP_REG_BIT_SET 5'h14
`define AEX_OP_SKIP_IO_BIT_CLEAR 5'h15
`define AEX_OP_SKIP_IO_BIT_SET 5'h16
`define AEX_OP_BRANCH_FLAG_SET 5'h17
`define AEX_OP_BRANCH_FLAG_CLEAR 5'h18

// axi responses
`define AEX_RESP_OKAY 2'h0
`define AEX_RESP_SLVERR 2'h2

`endif

//--- design/aex_alu.v
`timescale 1ns/1ps
`include "aex_map.vh"

// data path of the arithmetic and logic group, purely combinational
module aex_alu (
	input wire [4:0] op,
	input wire [7:0] rd_val,
	input wire [7:0] rr_val,
	input wire [7:0] imm,
	input wire [7:0] flags_in,
	output reg [7:0] res_lo,
	output reg [7:0] res_hi,
	output reg wr_lo,
	output reg wr_hi,
	output reg [7:0] flags_out
);
	reg [7:0] b8;
	reg cin;
	reg is_sub;
	reg [8:0] sum9;
	reg [8:0] diff9;
	reg [16:0] w17;
	reg [7:0] r;

	// pick operands, then set result and the flags each group touches
	always @* begin
		b8 = rr_val;
		cin = 1'b0;
		is_sub = 1'b0;
		case (op)
		`AEX_OP_SUBTRACT_IMMEDIATE, `AEX_OP_COMPARE_WITH_CONSTANT: begin
			b8 = imm;
			is_sub = 1'b1;
		end
		`AEX_OP_SUBTRACT_IMMEDIATE_WITH_CARRY: begin
			b8 = imm;
			is_sub = 1'b1;
			cin = flags_in[`AEX_FLAG_C];
		end
		`AEX_OP_SUB, `AEX_OP_WORD_SUBTRACT_IMMEDIATE: is_sub = 1'b1;
		`AEX_OP_SUBTRACT_WITH_CARRY: begin
			is_sub = 1'b1;
			cin = flags_in[`AEX_FLAG_C];
		end
		`AEX_OP_ADD_CARRY: cin = flags_in[`AEX_FLAG_C];
		`AEX_OP_AND_WITH_CONSTANT, `AEX_OP_OR_WITH_CONSTANT, `AEX_OP_SET_BITS_OP: b8 = imm;
		`AEX_OP_CLEAR_BITS_OP: b8 = ~imm;
		`AEX_OP_REGISTER_TEST_OP: b8 = rd_val;
		default: b8 = rr_val;
		endcase
		sum9 = {1'b0, rd_val} + {1'b0, b8} + {8'h00, cin};
		diff9 = {1'b0, rd_val} - {1'b0, b8} - {8'h00, cin};
		// word ops treat rr_val as the high byte of the pair
		if (is_sub)
			w17 = {1'b0, rr_val, rd_val} - {9'h000, imm};
		else
			w17 = {1'b0, rr_val, rd_val} + {9'h000, imm};
		r = is_sub ? diff9[7:0] : sum9[7:0];
		res_lo = r;
		res_hi = rr_val;
		wr_lo = 1'b0;
		wr_hi = 1'b0;
		flags_out = flags_in;
		case (op)
		`AEX_OP_ADD, `AEX_OP_ADD_CARRY: begin
			wr_lo = 1'b1;
			flags_out[`AEX_FLAG_C] = sum9[8];
			flags_out[`AEX_FLAG_H] = (rd_val[3] & b8[3]) | (b8[3] & ~r[3]) | (~r[3] & rd_val[3]);
			flags_out[`AEX_FLAG_V] = (rd_val[7] & b8[7] & ~r[7]) | (~rd_val[7] & ~b8[7] & r[7]);
			flags_out[`AEX_FLAG_N] = r[7];
			flags_out[`AEX_FLAG_Z] = (r == 8'h00);
		end
		`AEX_OP_SUB, `AEX_OP_SUBTRACT_IMMEDIATE, `AEX_OP_SUBTRACT_WITH_CARRY,
		`AEX_OP_SUBTRACT_IMMEDIATE_WITH_CARRY, `AEX_OP_COMPARE_WITH_CONSTANT: begin
			// compare keeps the register, only the flags move
			wr_lo = (op != `AEX_OP_COMPARE_WITH_CONSTANT);
			flags_out[`AEX_FLAG_C] = diff9[8];
			flags_out[`AEX_FLAG_H] = (~rd_val[3] & b8[3]) | (b8[3] & r[3]) | (r[3] & ~rd_val[3]);
			flags_out[`AEX_FLAG_V] = (rd_val[7] & ~b8[7] & ~r[7]) | (~rd_val[7] & b8[7] & r[7]);
			flags_out[`AEX_FLAG_N] = r[7];
			flags_out[`AEX_FLAG_Z] = (r == 8'h00);
		end
		`AEX_OP_WORD_ADD_IMMEDIATE, `AEX_OP_WORD_SUBTRACT_IMMEDIATE: begin
			wr_lo = 1'b1;
			wr_hi = 1'b1;
			res_lo = w17[7:0];
			res_hi = w17[15:8];
			flags_out[`AEX_FLAG_C] = w17[16];
			flags_out[`AEX_FLAG_V] = is_sub ? (rr_val[7] & ~w17[15]) : (~rr_val[7] & w17[15]);
			flags_out[`AEX_FLAG_N] = w17[15];
			flags_out[`AEX_FLAG_S] = w17[15] ^ flags_out[`AEX_FLAG_V];
			flags_out[`AEX_FLAG_Z] = (w17[15:0] == 16'h0000);
		end
		`AEX_OP_AND, `AEX_OP_AND_WITH_CONSTANT, `AEX_OP_CLEAR_BITS_OP, `AEX_OP_REGISTER_TEST_OP,
		`AEX_OP_OR, `AEX_OP_OR_WITH_CONSTANT, `AEX_OP_SET_BITS_OP: begin
			// carry and half-carry are left alone by the logic group
			if (op == `AEX_OP_OR || op == `AEX_OP_OR_WITH_CONSTANT || op == `AEX_OP_SET_BITS_OP)
				res_lo = rd_val | b8;
			else
				res_lo = rd_val & b8;
			wr_lo = (op != `AEX_OP_REGISTER_TEST_OP);
			flags_out[`AEX_FLAG_V] = 1'b0;
			flags_out[`AEX_FLAG_N] = res_lo[7];
			flags_out[`AEX_FLAG_Z] = (res_lo == 8'h00);
		end
		default: flags_out = flags_in;
		endcase
	end
endmodule

//--- design/aex_core.v
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "aex_map.vh"

module aex_core #(
	parameter ADDR_W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg busy
);
	localparam ST_IDLE = 2'b01;
	localparam ST_EXEC = 2'b10;

	// sequencer and architectural state seen by software
	reg [1:0] state_r;
	reg [1:0] left_r;
	reg [31:0] ctrl_r;
	reg [31:0] oper_r;
	reg [15:0] pc_r;
	reg [15:0] zptr_r;
	reg [7:0] flags_r;
	reg [15:0] result_r;
	reg taken_r;
	reg [1:0] last_cyc_r;
	// write beat held until both halves are in
	reg [ADDR_W-1:0] waddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg aw_held_r;
	reg w_held_r;

	// fields of the control and operand words
	wire [4:0] op = ctrl_r[`AEX_CTRL_OP_LSB +: 5];
	wire [2:0] bsel = ctrl_r[`AEX_CTRL_BIT_LSB +: 3];
	wire two_word = ctrl_r[`AEX_CTRL_TWO_WORD];
	wire [6:0] koff = ctrl_r[`AEX_CTRL_K_LSB +: 7];
	wire [7:0] rd_val = oper_r[`AEX_OPER_RD_LSB +: 8];
	wire [7:0] rr_val = oper_r[`AEX_OPER_RR_LSB +: 8];
	wire [7:0] imm = oper_r[`AEX_OPER_K_LSB +: 8];
	wire [7:0] io_val = oper_r[`AEX_OPER_IO_LSB +: 8];

	// alu outputs, only used on the commit edge
	wire [7:0] alu_lo;
	wire [7:0] alu_hi;
	wire alu_wr_lo;
	wire alu_wr_hi;
	wire [7:0] alu_flags;

	// operands are frozen while busy, so the alu output is stable for the commit
	aex_alu u_alu (
		.op(op),
		.rd_val(rd_val),
		.rr_val(rr_val),
		.imm(imm),
		.flags_in(flags_r),
		.res_lo(alu_lo),
		.res_hi(alu_hi),
		.wr_lo(alu_wr_lo),
		.wr_hi(alu_wr_hi),
		.flags_out(alu_flags)
	);

	// flow decode, one copy shared by skip and branch
	reg cond;
	reg is_skip;
	reg is_branch;
	reg [1:0] cyc;
	reg [15:0] pc_nxt;

	// condition, cycle count and next pc for the program-flow group
	always @* begin
		cond = 1'b0;
		is_skip = 1'b0;
		is_branch = 1'b0;
		case (op)
		`AEX_OP_COMPARE_SKIP_EQUAL: begin
			is_skip = 1'b1;
			cond = (rd_val == rr_val);
		end
		`AEX_OP_SKIP_REG_BIT_CLEAR: begin
			is_skip = 1'b1;
			cond = ~rr_val[bsel];
		end
		`AEX_OP_SKIP_REG_BIT_SET: begin
			is_skip = 1'b1;
			cond = rr_val[bsel];
		end
		`AEX_OP_SKIP_IO_BIT_CLEAR: begin
			is_skip = 1'b1;
			cond = ~io_val[bsel];
		end
		`AEX_OP_SKIP_IO_BIT_SET: begin
			is_skip = 1'b1;
			cond = io_val[bsel];
		end
		`AEX_OP_BRANCH_FLAG_SET: begin
			is_branch = 1'b1;
			cond = flags_r[bsel];
		end
		`AEX_OP_BRANCH_FLAG_CLEAR: begin
			is_branch = 1'b1;
			cond = ~flags_r[bsel];
		end
		default: cond = 1'b0;
		endcase
		// cycle count of the operation
		case (op)
		`AEX_OP_WORD_ADD_IMMEDIATE, `AEX_OP_WORD_SUBTRACT_IMMEDIATE: cyc = `AEX_CYC_TWO;
		`AEX_OP_POINTER_JUMP: cyc = `AEX_CYC_TWO;
		`AEX_OP_POINTER_CALL: cyc = `AEX_CYC_THREE;
		default: cyc = `AEX_CYC_ONE;
		endcase
		if (is_skip && cond)
			cyc = two_word ? `AEX_CYC_THREE : `AEX_CYC_TWO;
		if (is_branch && cond)
			cyc = `AEX_CYC_TWO;
		// next program counter
		pc_nxt = pc_r + 16'h0001;
		if (op == `AEX_OP_POINTER_JUMP || op == `AEX_OP_POINTER_CALL)
			pc_nxt = zptr_r;
		else if (is_skip && cond)
			pc_nxt = pc_r + (two_word ? 16'h0003 : 16'h0002);
		else if (is_branch && cond)
			pc_nxt = pc_r + {{9{koff[6]}}, koff} + 16'h0001;
	end

	// byte-lane merge for partial writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] din;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = din[i*8 +: 8];
		end
	endfunction

	wire do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
	wire [ADDR_W-1:0] wa = waddr_r;
	wire mapped_w = (wa == `AEX_OFF_CTRL) || (wa == `AEX_OFF_OPER) || (wa == `AEX_OFF_PC) ||
		(wa == `AEX_OFF_ZPTR) || (wa == `AEX_OFF_FLAGS) || (wa == `AEX_OFF_RESULT) ||
		(wa == `AEX_OFF_STATUS);
	// software may only steer the core while it is idle
	wire sw_wr = do_write & (state_r == ST_IDLE);
	wire start = sw_wr & (wa == `AEX_OFF_CTRL) & wstrb_r[3] & wdata_r[`AEX_CTRL_START];
	wire [31:0] pc_word = merge({16'h0000, pc_r}, wdata_r, wstrb_r);
	wire [31:0] z_word = merge({16'h0000, zptr_r}, wdata_r, wstrb_r);
	wire [31:0] fl_word = merge({24'h000000, flags_r}, wdata_r, wstrb_r);

	// write channel: address and data taken in either order, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AEX_RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= {ADDR_W{1'b0}};
			wdata_r <= `AEX_RST_WORD;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				waddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped_w ? `AEX_RESP_OKAY : `AEX_RESP_SLVERR;
			end
			// ready comes back only once the response has gone
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register file plus sequencer; commits win because bus writes are blocked while busy
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			left_r <= 2'h0;
			busy <= 1'b0;
			ctrl_r <= `AEX_RST_WORD;
			oper_r <= `AEX_RST_WORD;
			pc_r <= `AEX_RST_PC;
			zptr_r <= `AEX_RST_PC;
			flags_r <= `AEX_RST_FLAGS;
			result_r <= 16'h0000;
			taken_r <= 1'b0;
			last_cyc_r <= 2'h0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (sw_wr) begin
					case (wa)
					`AEX_OFF_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h007f_01ff;
					`AEX_OFF_OPER: oper_r <= merge(oper_r, wdata_r, wstrb_r);
					`AEX_OFF_PC: pc_r <= pc_word[15:0];
					`AEX_OFF_ZPTR: zptr_r <= z_word[15:0];
					`AEX_OFF_FLAGS: flags_r <= fl_word[7:0];
					default: ;
					endcase
				end
				// start uses the control fields written in the same beat
				if (start) begin
					ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h007f_01ff;
					state_r <= ST_EXEC;
					busy <= 1'b1;
				end
			end
			ST_EXEC: begin
				if (left_r == 2'h0) begin
					left_r <= cyc - 2'h1;
					last_cyc_r <= cyc;
					taken_r <= cond;
				end else begin
					left_r <= left_r - 2'h1;
				end
				// commit on the final cycle of the operation
				if ((left_r == 2'h1) || (left_r == 2'h0 && cyc == `AEX_CYC_ONE)) begin
					state_r <= ST_IDLE;
					busy <= 1'b0;
					left_r <= 2'h0;
					pc_r <= pc_nxt;
					flags_r <= alu_flags;
					if (alu_wr_lo)
						oper_r[`AEX_OPER_RD_LSB +: 8] <= alu_lo;
					if (alu_wr_hi)
						oper_r[`AEX_OPER_RR_LSB +: 8] <= alu_hi;
					// call leaves its return address here for software to read at the result offset
					if (op == `AEX_OP_POINTER_CALL)
						result_r <= pc_r + 16'h0001;
					else
						result_r <= {alu_hi, alu_lo};
				end
			end
			default: begin
				state_r <= ST_IDLE;
				busy <= 1'b0;
			end
			endcase
		end
	end

	// status packs busy, last condition and cycles
	reg [31:0] rd_mux;
	reg rd_ok;

	// read decode; unmapped addresses answer zero with slverr
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
		`AEX_OFF_CTRL: rd_mux = ctrl_r;
		`AEX_OFF_OPER: rd_mux = oper_r;
		`AEX_OFF_PC: rd_mux = {16'h0000, pc_r};
		`AEX_OFF_ZPTR: rd_mux = {16'h0000, zptr_r};
		`AEX_OFF_FLAGS: rd_mux = {24'h000000, flags_r};
		`AEX_OFF_RESULT: rd_mux = {16'h0000, result_r};
		`AEX_OFF_STATUS: rd_mux = {28'h0000000, last_cyc_r, taken_r, busy};
		default: begin
			rd_mux = 32'h0000_0000;
			rd_ok = 1'b0;
		end
		endcase
	end

	// read channel: one outstanding read, data one edge after the address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `AEX_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `AEX_RESP_OKAY : `AEX_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

//--- bench/aex_core_props.sv
`timescale 1ns/1ps
`include "aex_map.vh"

// watches the bus handshakes and the length of each busy phase
module aex_props #(
	parameter ADDR_W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire busy
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// both halves of a write taken on one edge
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// start request on the control word while idle
	sequence s_start;
		s_wr_take ##0 (s_axi_awaddr == `AEX_OFF_CTRL && s_axi_wstrb[3] && s_axi_wdata[31] && !busy);
	endsequence

	// start of an op that always takes one cycle
	sequence s_go_one;
		s_start ##0 (s_axi_wdata[4:0] inside {5'h00, 5'h01, [5'h03:5'h06], [5'h08:5'h0e], 5'h12});
	endsequence
	// start of a word op or a pointer jump
	sequence s_go_two;
		s_start ##0 (s_axi_wdata[4:0] inside {5'h02, 5'h07, 5'h0f});
	endsequence
	// start of a pointer call
	sequence s_go_call;
		s_start ##0 (s_axi_wdata[4:0] == `AEX_OP_POINTER_CALL);
	endsequence

	// take at t, held beat commits at t+1, bvalid seen from t+2
	a_resp_follows: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write reopened early");
	// busy rises one edge after the take, so it is first seen two edges on
	a_one_cycle: assert property (s_go_one |-> ##2 busy ##1 !busy) else $error("alu op not one cycle");
	a_word_two: assert property (s_go_two |-> ##2 busy [*2] ##1 !busy) else $error("two cycle op wrong");
	a_call_three: assert property (s_go_call |-> ##2 busy [*3] ##1 !busy) else $error("call not three");
	a_busy_bounded: assert property ($rose(busy) |-> ##[1:3] !busy) else $error("busy too long");
endmodule

//--- bench/alu_and_branch_execute_tb.sv
`timescale 1ns/1ps
`include "aex_map.vh"

module alu_and_branch_execute_tb;
	// ctrl, oper in, flags in, oper out, flags out, pc out, status[3:1]
	typedef struct {logic [31:0] c, o; logic [7:0] f; logic [31:0] eo; logic [7:0] ef; logic [15:0] ep; logic [2:0] es;} aex_row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int err_count = 0;
	int n_tests = 0;
	logic [1:0] rs;
	logic [31:0] d;
	aex_row_t rows [27] = '{
		'{32'h00, 32'h0000017f, 8'h00, 32'h00000180, 8'h2c, 16'h11, 3'h2},
		'{32'h01, 32'h000000ff, 8'h01, 32'h00000000, 8'h23, 16'h11, 3'h2},
		'{32'h02, 32'h00017fff, 8'h20, 32'h00018000, 8'h2c, 16'h11, 3'h4},
		'{32'h03, 32'h00000100, 8'h00, 32'h000001ff, 8'h25, 16'h11, 3'h2},
		'{32'h04, 32'h00010080, 8'h00, 32'h0001007f, 8'h28, 16'h11, 3'h2},
		'{32'h05, 32'h00000505, 8'h01, 32'h000005ff, 8'h25, 16'h11, 3'h2},
		'{32'h06, 32'h000f0010, 8'h00, 32'h000f0001, 8'h20, 16'h11, 3'h2},
		'{32'h07, 32'h00010000, 8'h00, 32'h0001ffff, 8'h15, 16'h11, 3'h4},
		'{32'h08, 32'h00000ff0, 8'h29, 32'h00000f00, 8'h23, 16'h11, 3'h2},
		'{32'h09, 32'h008000ff, 8'h21, 32'h00800080, 8'h25, 16'h11, 3'h2},
		'{32'h0a, 32'h00000000, 8'h08, 32'h00000000, 8'h02, 16'h11, 3'h2},
		'{32'h0b, 32'h00800001, 8'h00, 32'h00800081, 8'h04, 16'h11, 3'h2},
		'{32'h0c, 32'h0030000f, 8'h00, 32'h0030003f, 8'h00, 16'h11, 3'h2},
		'{32'h0d, 32'h000f00ff, 8'h01, 32'h000f00f0, 8'h05, 16'h11, 3'h2},
		'{32'h0e, 32'h00005500, 8'h0c, 32'h00005500, 8'h02, 16'h11, 3'h2},
		'{32'h0f, 32'h12345678, 8'h3f, 32'h12345678, 8'h3f, 16'h1234, 3'h4},
		'{32'h10, 32'h12345678, 8'h3f, 32'h12345678, 8'h3f, 16'h1234, 3'h6},
		'{32'h11, 32'h00004242, 8'h15, 32'h00004242, 8'h15, 16'h12, 3'h5},
		'{32'h11, 32'h00004342, 8'h15, 32'h00004342, 8'h15, 16'h11, 3'h2},
		'{32'h12, 32'h00200010, 8'h00, 32'h00200010, 8'h05, 16'h11, 3'h2},
		'{32'h153, 32'h0000fbfb, 8'h00, 32'h0000fbfb, 8'h00, 16'h13, 3'h7},
		'{32'h54, 32'h0000fbfb, 8'h00, 32'h0000fbfb, 8'h00, 16'h11, 3'h2},
		'{32'hf5, 32'h80000000, 8'h00, 32'h80000000, 8'h00, 16'h11, 3'h2},
		'{32'hf6, 32'h80000000, 8'h00, 32'h80000000, 8'h00, 16'h12, 3'h5},
		'{32'h7e0037, 32'h0, 8'h02, 32'h0, 8'h02, 16'h0f, 3'h5},
		'{32'h18, 32'h0, 8'h01, 32'h0, 8'h01, 16'h11, 3'h2},
		'{32'h3f0078, 32'h0, 8'h00, 32'h0, 8'h00, 16'h50, 3'h5}
	};

	aex_core u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .busy(busy)
	);

	// free running system clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask

	// called right after an edge; bready goes up with the request, or only once bvalid shows when late
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r, input bit late = 1'b0);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !late;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		// bready is left up; the next call sets it in one assignment
		r = s_axi_bresp;
		if (i == 50) begin
			err_count++;
			wrap_up();
		end
	endtask

	// rready goes up with the request; a late caller makes the answer stand a cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r, input bit late = 1'b0);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !late;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		v = s_axi_rdata;
		r = s_axi_rresp;
		if (i == 50) begin
			err_count++;
			wrap_up();
		end
	endtask

	// poll status until the core goes idle
	task automatic idle();
		int i;
		for (i = 0; i < 40; i++) begin
			rd(`AEX_OFF_STATUS, d, rs);
			if (d[0] === 1'b0) break;
		end
		if (i == 40) begin
			err_count++;
			wrap_up();
		end
	endtask

	task automatic run(input aex_row_t r);
		wr(`AEX_OFF_OPER, r.o, rs);
		wr(`AEX_OFF_PC, 32'h10, rs);
		wr(`AEX_OFF_ZPTR, 32'h1234, rs);
		wr(`AEX_OFF_FLAGS, {24'h0, r.f}, rs);
		wr(`AEX_OFF_CTRL, r.c | 32'h8000_0000, rs);
		idle();
		rd(`AEX_OFF_OPER, d, rs);
		chk("oper", r.eo, d);
		rd(`AEX_OFF_PC, d, rs);
		chk("pc", {16'h0, r.ep}, d);
		rd(`AEX_OFF_FLAGS, d, rs);
		chk("flags", {24'h0, r.ef}, d);
		rd(`AEX_OFF_STATUS, d, rs);
		chk("status", {28'h0, r.es, 1'b0}, d);
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_awprot = 3'h0;
		s_axi_arprot = 3'h0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// one row per operation and outcome
		for (int k = 0; k < 27; k++) begin
			run(rows[k]);
			$display("row %0d done", k);
		end
		// return address of a pointer call
		run(rows[16]);
		rd(`AEX_OFF_RESULT, d, rs);
		chk("result", 32'h11, d);
		$display("call return test done");
		// a pointer write landing on the last busy edge of a call must be dropped
		wr(`AEX_OFF_ZPTR, 32'h0200, rs);
		wr(`AEX_OFF_CTRL, 32'h8000_0010, rs);
		wr(`AEX_OFF_ZPTR, 32'h0aaa, rs);
		idle();
		rd(`AEX_OFF_PC, d, rs);
		chk("pc busy", 32'h0200, d);
		rd(`AEX_OFF_ZPTR, d, rs);
		chk("zptr busy", 32'h0200, d);
		$display("busy write test done");
		// unmapped offset answers with an error; late ready makes each answer stand
		wr(8'h1c, 32'h1, rs, 1'b1);
		chk("bresp", {30'h0, `AEX_RESP_SLVERR}, {30'h0, rs});
		rd(8'h1c, d, rs, 1'b1);
		chk("rresp", {30'h0, `AEX_RESP_SLVERR}, {30'h0, rs});
		chk("rdata", 32'h0, d);
		$display("unmapped test done");
		// second reset clears the registers
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`AEX_OFF_PC, d, rs);
		chk("pc reset", {16'h0, `AEX_RST_PC}, d);
		rd(`AEX_OFF_FLAGS, d, rs);
		chk("flags reset", {24'h0, `AEX_RST_FLAGS}, d);
		rd(`AEX_OFF_OPER, d, rs);
		chk("oper reset", `AEX_RST_WORD, d);
		$display("reset test done");
		wrap_up();
	end
endmodule

bind aex_core aex_props #(.ADDR_W(ADDR_W)) u_props (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .busy(busy)
);
